// ### rtl/gas_supervisor.v
`timescale 1ns/100ps
`include "gas_defines.vh"
module gas_supervisor
#(
  parameter TICK_CYC = (`GAS_CLK_HZ/1000)*`GAS_TICK_MS,
  parameter SEC_T = `GAS_SEC_MS/`GAS_TICK_MS,
  parameter WARMUP_T = `GAS_WARMUP_MS/`GAS_TICK_MS,
  parameter FLASH_HALF_T = `GAS_FLASH_MS/2/`GAS_TICK_MS,
  parameter HOLD_T = (`GAS_HOLD_MS+`GAS_TICK_MS-1)/`GAS_TICK_MS,
  parameter TEST_TO_T = `GAS_TEST_TO_MS/`GAS_TICK_MS,
  parameter SETUP_TO_T = `GAS_SETUP_TO_MS/`GAS_TICK_MS
)
(
  input wire core_clk,
  input wire reset,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] sensor_level,
  input wire sensor_absent,
  input wire sensor_fault,
  input wire sensor_board_missing,
  input wire equip_fault,
  input wire key_test,
  input wire function_key,
  input wire key_reset,
  input wire key_up,
  input wire key_down,
  input wire buzzer_silence_key,
  input wire ext_reset_short,
  output wire [2:0] alarm_relay,
  output reg trouble_relay,
  output reg [2:0] alarm_led,
  output reg trouble_led,
  output reg warn_lamp,
  output reg buzzer,
  output reg [15:0] seven_segment_display,
  output reg [2:0] disp_msg,
  output reg disp_blank
);
  localparam ST_SELF = 3'h0;
  localparam ST_MEAS = 3'h1;
  localparam ST_TEST = 3'h2;
  localparam ST_LAMP = 3'h3;
  localparam ST_SETUP = 3'h4;
  localparam ST_EFLT = 3'h5;
  localparam MSG_NUM = 3'h0;
  localparam MSG_SELF = 3'h1;
  localparam MSG_FAULT = 3'h2;
  localparam MSG_UNDER = 3'h3;
  localparam MSG_OVER = 3'h4;
  localparam MSG_MENU = 3'h5;
  localparam MSG_LAMP = 3'h6;
  localparam MSG_PASS = 3'h7;
  localparam K_TEST = 0;
  localparam K_FUNCTION_KEY = 1;
  localparam K_RST = 2;
  localparam K_UP = 3;
  localparam K_DN = 4;
  localparam K_BZ = 5;

  function [3:0] reg_idx;
    input [7:0] a;
    begin
      if (a == `GAS_CTRL_OFS)
        reg_idx = 4'h0;
      else if (a == `GAS_AL1_OFS)
        reg_idx = 4'h1;
      else if (a == `GAS_AL2_OFS)
        reg_idx = 4'h2;
      else if (a == `GAS_AL3_OFS)
        reg_idx = 4'h3;
      else if (a == `GAS_DWELL_OFS)
        reg_idx = 4'h4;
      else if (a == `GAS_HSCALE_OFS)
        reg_idx = 4'h5;
      else if (a == `GAS_TESTVAL_OFS)
        reg_idx = 4'h6;
      else if (a == `GAS_PASS_OFS)
        reg_idx = 4'h7;
      else if (a == `GAS_STAT_OFS)
        reg_idx = 4'h8;
      else if (a == `GAS_DISP_OFS)
        reg_idx = 4'h9;
      else
        reg_idx = 4'hF;
    end
  endfunction

  function [31:0] strb_merge;
    input [31:0] o;
    input [31:0] n;
    input [3:0] s;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        strb_merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  reg [2:0] state_r;
  reg [31:0] pre_r, sec_r, flash_cnt_r, idle_r, tmr_r;
  reg flash_r, eqf_r, unlock_r, silence_r, cause_prev_r, clr_r;
  reg [2:0] menu_r;
  reg [6:0] pw_try_r;
  reg [5:0] key_prev_r;
  reg [15:0] peak_r;
  reg latch_r;
  reg [47:0] thr_r;
  reg [14:0] dwell_r;
  reg [15:0] hscale_r, testval_r;
  reg [6:0] pass_r;
  reg aw_ok_r, w_ok_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg [31:0] rd_word;
  wire [31:0] m = strb_merge(32'h0, wdata_r, wstrb_r);
  wire [2:0] alarm_on;
  wire [1:0] long_hold;

  wire tick = (pre_r == TICK_CYC - 1);
  wire sec_tick = tick && (sec_r == SEC_T - 1);
  wire [5:0] keys = {buzzer_silence_key, key_down, key_up, key_reset, function_key, key_test};
  wire [5:0] key_rise = keys & ~key_prev_r;
  wire meas = (state_r == ST_MEAS);
  wire in_test = (state_r == ST_TEST) || (state_r == ST_LAMP);
  wire live = meas || in_test;
  wire sens_flt = sensor_absent | sensor_fault | sensor_board_missing;

  // Scaled by ten so the ten-percent margins need no divider
  wire signed [21:0] lvl_ext = {{6{sensor_level[15]}}, sensor_level};
  wire signed [21:0] lvl_x10 = (lvl_ext <<< 3) + (lvl_ext <<< 1);
  wire signed [21:0] hs_ext = {6'h00, hscale_r};
  wire signed [21:0] hs_x11 = (hs_ext <<< 3) + (hs_ext <<< 1) + hs_ext;
  wire signed [21:0] under_d = lvl_x10 + hs_ext;
  wire signed [21:0] over_d = hs_x11 - lvl_x10;
  wire fault_c = live && sens_flt;
  wire under_c = live && !sens_flt && under_d[21];
  wire over_c = live && !sens_flt && over_d[21];
  wire [15:0] conc_meas = sensor_level[15] ? 16'h0000 : sensor_level;
  wire [15:0] conc_eff = (state_r == ST_TEST) ? testval_r :
    (meas && !sens_flt) ? conc_meas : 16'h0000;
  wire trb = fault_c || under_c || (state_r == ST_EFLT);
  wire buzz_cause = trb || over_c || (|alarm_on);
  wire held = latch_r && (|alarm_on);
  wire alarm_clr = key_rise[K_RST] || ext_reset_short || clr_r;

  assign alarm_relay = alarm_on;
  assign s_axi_awready = !aw_ok_r && !s_axi_bvalid;
  assign s_axi_wready = !w_ok_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : ch
      gas_alarm_chan #(.CW(16), .DW(5)) u_chan
      (
        .core_clk(core_clk),
        .reset(reset),
        .conc(conc_eff),
        .thresh(thr_r[16*g +: 16]),
        .dwell(dwell_r[5*g +: 5]),
        .sec_tick(sec_tick),
        .latch_en(latch_r),
        .clear(alarm_clr),
        .alarm_on(alarm_on[g])
      );
    end
    for (g = 0; g < 2; g = g + 1)
    begin : hk
      reg [31:0] cnt_r;
      always @(posedge core_clk)
      begin
        if (reset || !keys[g])
          cnt_r <= 32'h0;
        else if (tick && cnt_r < HOLD_T)
          cnt_r <= cnt_r + 32'h1;
      end
      assign long_hold[g] = (cnt_r >= HOLD_T);
    end
  endgenerate

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      pre_r <= 32'h0;
      sec_r <= 32'h0;
      flash_cnt_r <= 32'h0;
      flash_r <= 1'b0;
      key_prev_r <= 6'h00;
      idle_r <= 32'h0;
    end
    else
    begin
      pre_r <= tick ? 32'h0 : pre_r + 32'h1;
      key_prev_r <= keys;
      if (tick)
      begin
        sec_r <= (sec_r == SEC_T - 1) ? 32'h0 : sec_r + 32'h1;
        if (flash_cnt_r == FLASH_HALF_T - 1)
        begin
          flash_cnt_r <= 32'h0;
          flash_r <= !flash_r;
        end
        else
          flash_cnt_r <= flash_cnt_r + 32'h1;
      end
      if ((|key_rise) || meas)
        idle_r <= 32'h0;
      else if (tick)
        idle_r <= idle_r + 32'h1;
    end
  end

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      state_r <= ST_SELF;
      tmr_r <= 32'h0;
      eqf_r <= 1'b0;
      unlock_r <= 1'b0;
      menu_r <= 3'h0;
      pw_try_r <= 7'h00;
    end
    else
    begin
      case (state_r)
        ST_SELF:
        begin
          eqf_r <= eqf_r | equip_fault;
          if (tick)
          begin
            if (tmr_r >= WARMUP_T - 1)
              state_r <= (eqf_r | equip_fault) ? ST_EFLT : ST_MEAS;
            else
              tmr_r <= tmr_r + 32'h1;
          end
        end
        ST_MEAS:
        begin
          if (long_hold[K_TEST])
            state_r <= ST_TEST;
          else if (long_hold[K_FUNCTION_KEY])
          begin
            state_r <= ST_SETUP;
            unlock_r <= (pass_r == 7'h00);
            pw_try_r <= 7'h00;
            menu_r <= 3'h0;
          end
        end
        ST_TEST, ST_LAMP:
        begin
          if (key_rise[K_RST] || idle_r >= TEST_TO_T)
            state_r <= ST_MEAS;
          else if (long_hold[K_FUNCTION_KEY])
            state_r <= ST_LAMP;
        end
        ST_SETUP:
        begin
          if (key_rise[K_RST] || idle_r >= SETUP_TO_T)
            state_r <= ST_MEAS;
          else if (!unlock_r)
          begin
            if (key_rise[K_UP])
              pw_try_r <= (pw_try_r == `GAS_PASS_MAX) ? 7'h00 : pw_try_r + 7'h01;
            else if (key_rise[K_DN])
              pw_try_r <= (pw_try_r == 7'h00) ? `GAS_PASS_MAX : pw_try_r - 7'h01;
            else if (key_rise[K_FUNCTION_KEY] && pw_try_r == pass_r)
              unlock_r <= 1'b1;
          end
          else if (key_rise[K_UP])
            menu_r <= (menu_r == `GAS_MENU_LAST) ? 3'h0 : menu_r + 3'h1;
          else if (key_rise[K_DN])
            menu_r <= (menu_r == 3'h0) ? `GAS_MENU_LAST : menu_r - 3'h1;
        end
        ST_EFLT:
          state_r <= ST_EFLT;
        default:
          state_r <= ST_SELF;
      endcase
    end
  end

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      peak_r <= 16'h0000;
      silence_r <= 1'b0;
      cause_prev_r <= 1'b0;
      trouble_relay <= 1'b0;
      trouble_led <= 1'b0;
      alarm_led <= 3'h0;
      warn_lamp <= 1'b0;
      buzzer <= 1'b0;
      seven_segment_display <= 16'h0000;
      disp_msg <= MSG_SELF;
      disp_blank <= 1'b0;
    end
    else
    begin
      if (held && conc_eff < peak_r)
        peak_r <= peak_r;
      else
        peak_r <= conc_eff;
      cause_prev_r <= buzz_cause;
      // A new cause re-arms the buzzer even if silenced in the same cycle
      if (buzz_cause && !cause_prev_r)
        silence_r <= 1'b0;
      else if (key_rise[K_BZ])
        silence_r <= 1'b1;
      else if (!buzz_cause)
        silence_r <= 1'b0;
      trouble_relay <= trb;
      trouble_led <= trb || (state_r == ST_LAMP);
      if (state_r == ST_LAMP)
        alarm_led <= 3'h7;
      else if (over_c)
        alarm_led <= {3{flash_r}};
      else
        alarm_led <= alarm_on;
      if (state_r == ST_LAMP)
        warn_lamp <= 1'b1;
      else
        warn_lamp <= buzz_cause && ((silence_r && !over_c) || flash_r);
      buzzer <= (buzz_cause && (!silence_r || in_test)) ||
        (state_r == ST_LAMP);
      disp_blank <= 1'b0;
      seven_segment_display <= conc_meas;
      case (state_r)
        ST_SELF:
        begin
          disp_msg <= MSG_SELF;
          disp_blank <= !flash_r;
        end
        ST_EFLT:
        begin
          disp_msg <= MSG_FAULT;
          disp_blank <= !flash_r;
        end
        ST_LAMP:
        begin
          disp_msg <= MSG_LAMP;
          seven_segment_display <= 16'hFFFF;
        end
        ST_SETUP:
        begin
          disp_msg <= unlock_r ? MSG_MENU : MSG_PASS;
          seven_segment_display <= unlock_r ? {13'h0000, menu_r} : {9'h000, pw_try_r};
        end
        ST_TEST:
        begin
          disp_msg <= MSG_NUM;
          seven_segment_display <= testval_r;
          disp_blank <= !flash_r;
        end
        default:
        begin
          if (fault_c)
          begin
            disp_msg <= MSG_FAULT;
            disp_blank <= !flash_r;
          end
          else if (over_c)
          begin
            disp_msg <= MSG_OVER;
            disp_blank <= !flash_r;
          end
          else if (under_c)
          begin
            disp_msg <= MSG_UNDER;
            disp_blank <= !flash_r;
          end
          else
          begin
            disp_msg <= MSG_NUM;
            if (held)
              seven_segment_display <= peak_r;
          end
        end
      endcase
    end
  end

  always @*
  begin
    rd_word = 32'h0;
    case (reg_idx(s_axi_araddr))
      4'h0: rd_word = {31'h0, latch_r};
      4'h1: rd_word = {16'h0, thr_r[15:0]};
      4'h2: rd_word = {16'h0, thr_r[31:16]};
      4'h3: rd_word = {16'h0, thr_r[47:32]};
      4'h4: rd_word = {11'h0, dwell_r[14:10], 3'h0, dwell_r[9:5], 3'h0, dwell_r[4:0]};
      4'h5: rd_word = {16'h0, hscale_r};
      4'h6: rd_word = {16'h0, testval_r};
      4'h7: rd_word = {25'h0, pass_r};
      4'h8: rd_word = {16'h0, unlock_r, menu_r, 1'b0, state_r, eqf_r, over_c, under_c,
        fault_c, trb, alarm_on};
      4'h9: rd_word = {13'h0, disp_msg, seven_segment_display};
      default: rd_word = 32'h0;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
      clr_r <= 1'b0;
      latch_r <= `GAS_CTRL_RST;
      thr_r <= {`GAS_AL3_RST, `GAS_AL2_RST, `GAS_AL1_RST};
      dwell_r <= {3{`GAS_DWELL_RST}};
      hscale_r <= `GAS_HSCALE_RST;
      testval_r <= `GAS_TESTVAL_RST;
      pass_r <= `GAS_PASS_RST;
    end
    else
    begin
      clr_r <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ok_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ok_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      else if (aw_ok_r && w_ok_r)
      begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (reg_idx(awaddr_r) > 4'h9) ? 2'h2 : 2'h0;
        if (reg_idx(awaddr_r) == 4'h0 && wstrb_r[0])
        begin
          latch_r <= wdata_r[`GAS_CTRL_LATCH];
          clr_r <= wdata_r[`GAS_CTRL_CLR];
        end
        else if (reg_idx(awaddr_r) == 4'h1)
          thr_r[15:0] <= m[15:0] | (thr_r[15:0] & {{8{!wstrb_r[1]}}, {8{!wstrb_r[0]}}});
        else if (reg_idx(awaddr_r) == 4'h2)
          thr_r[31:16] <= m[15:0] | (thr_r[31:16] & {{8{!wstrb_r[1]}}, {8{!wstrb_r[0]}}});
        else if (reg_idx(awaddr_r) == 4'h3)
          thr_r[47:32] <= m[15:0] | (thr_r[47:32] & {{8{!wstrb_r[1]}}, {8{!wstrb_r[0]}}});
        else if (reg_idx(awaddr_r) == 4'h4)
        begin
          if (wstrb_r[0])
            dwell_r[4:0] <= wdata_r[4:0];
          if (wstrb_r[1])
            dwell_r[9:5] <= wdata_r[`GAS_DWELL_STRIDE +: 5];
          if (wstrb_r[2])
            dwell_r[14:10] <= wdata_r[2*`GAS_DWELL_STRIDE +: 5];
        end
        else if (reg_idx(awaddr_r) == 4'h5)
          hscale_r <= m[15:0] | (hscale_r & {{8{!wstrb_r[1]}}, {8{!wstrb_r[0]}}});
        else if (reg_idx(awaddr_r) == 4'h6)
          testval_r <= m[15:0] | (testval_r & {{8{!wstrb_r[1]}}, {8{!wstrb_r[0]}}});
        else if (reg_idx(awaddr_r) == 4'h7 && wstrb_r[0])
          pass_r <= wdata_r[6:0];
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (reg_idx(s_axi_araddr) > 4'h9) ? 2'h2 : 2'h0;
      end
    end
  end
endmodule

// ### rtl/gas_defines.vh
// Summary of operation
// - Alarm asserts only after dwell count exceeded
// - Alarm relay energises once dwell is exceeded
// - Latched alarm holds until reset command
// - Latched alarm holds peak concentration display
// - Unlatched alarm clears when concentration drops below
// - Three alarm relays plus one trouble relay
// - Self-test flashes thirty seconds, then measuring
// - Self-test equipment fault raises fault alarm
// - Sensor fault flashes fault message, half-second period
// - Under-range below minus ten percent flashes message
// - Under-range: trouble lamp, flashing warning, buzzer
// - Silence key stops buzzer outside test, warning lamp steady except over-range
// - Over-range above 110 percent flashes message
// - Over-range flickers alarm lamps, warning, buzzer
// - Test key held two seconds enters test
// - Test mode exits after thirty idle minutes
// - Test mode flashes and alarms user value
// - Test: function hold lamp test, reset exits
// - Set-up exits after ten idle seconds
// - Password zero means no password required
// - Up and down cycle seven menu modes
// - Buzzer continuous on warning during test
`ifndef GAS_DEFINES_VH
`define GAS_DEFINES_VH
`define GAS_CLK_HZ 40000000
`define GAS_TICK_MS 1
`define GAS_SEC_MS 1000
`define GAS_WARMUP_MS 30000
`define GAS_FLASH_MS 500
`define GAS_HOLD_MS 2000
`define GAS_TEST_TO_MS 1800000
`define GAS_SETUP_TO_MS 10000
`define GAS_CTRL_OFS 8'h00
`define GAS_AL1_OFS 8'h04
`define GAS_AL2_OFS 8'h08
`define GAS_AL3_OFS 8'h0C
`define GAS_DWELL_OFS 8'h10
`define GAS_HSCALE_OFS 8'h14
`define GAS_TESTVAL_OFS 8'h18
`define GAS_PASS_OFS 8'h1C
`define GAS_STAT_OFS 8'h20
`define GAS_DISP_OFS 8'h24
`define GAS_CTRL_LATCH 0
`define GAS_CTRL_CLR 1
`define GAS_DWELL_STRIDE 8
`define GAS_CTRL_RST 1'b1
`define GAS_AL1_RST 16'h0014
`define GAS_AL2_RST 16'h0028
`define GAS_AL3_RST 16'h0032
`define GAS_DWELL_RST 5'h01
`define GAS_HSCALE_RST 16'h0064
`define GAS_TESTVAL_RST 16'h0000
`define GAS_PASS_RST 7'h00
`define GAS_PASS_MAX 7'h63
`define GAS_MENU_LAST 3'h6
`endif

// ### rtl/gas_alarm_chan.v
`timescale 1ns/100ps
module gas_alarm_chan
#(
  parameter CW = 16,
  parameter DW = 5
)
(
  input wire core_clk,
  input wire reset,
  input wire [CW-1:0] conc,
  input wire [CW-1:0] thresh,
  input wire [DW-1:0] dwell,
  input wire sec_tick,
  input wire latch_en,
  input wire clear,
  output reg alarm_on
);
  reg [DW:0] cnt_r;
  wire above = conc > thresh;
  wire below = conc < thresh;
  wire qual = cnt_r > {1'b0, dwell};

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      cnt_r <= {(DW+1){1'b0}};
      alarm_on <= 1'b0;
    end
    else
    begin
      if (!above)
        cnt_r <= {(DW+1){1'b0}};
      else if (sec_tick && !qual)
        cnt_r <= cnt_r + {{DW{1'b0}}, 1'b1};
      // A fresh qualification beats a clear in the same cycle
      if (above && qual)
        alarm_on <= 1'b1;
      else if (clear)
        alarm_on <= 1'b0;
      else if (!latch_en && below)
        alarm_on <= 1'b0;
    end
  end
endmodule

// ### dv/gas_sup_sva.sv
`timescale 1ns/100ps
module gas_sup_sva
#(
  parameter TICK_CYC = 4,
  parameter WARMUP_T = 50
)
(
  input logic core_clk,
  input logic reset,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic equip_fault,
  input logic [2:0] alarm_relay,
  input logic [2:0] alarm_led,
  input logic trouble_relay,
  input logic trouble_led,
  input logic [15:0] seven_segment_display,
  input logic [2:0] disp_msg,
  input logic disp_blank
);
  localparam int WARM = TICK_CYC * WARMUP_T;
  logic [19:0] cnt_r;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // Saturates so a long run never wraps back into the warm-up window
  always @(posedge core_clk)
  begin
    if (reset)
      cnt_r <= 20'h00000;
    else if (cnt_r != 20'hFFFFF)
      cnt_r <= cnt_r + 20'h00001;
  end
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_trouble_led: assert property (trouble_relay |-> trouble_led)
    else $error("trouble lamp off with trouble relay on");
  a_lamp_all_on: assert property (disp_msg == 3'h6 && $past(disp_msg) == 3'h6 |->
    seven_segment_display == 16'hFFFF && alarm_led == 3'h7) else $error("lamp test incomplete");
  a_over_flicker: assert property (disp_msg == 3'h4 && $past(disp_msg) == 3'h4 |->
    alarm_led == 3'h0 || alarm_led == 3'h7) else $error("alarm lamps not flickering together");
  a_fault_flash: assert property ($fell(disp_blank) && disp_msg == 3'h2 &&
    $past(disp_msg, 10) == 3'h2 |-> $past(disp_blank, 8)) else $error("fault flash too fast");
  a_warm_self: assert property (cnt_r < WARM - 12 && !equip_fault |-> disp_msg == 3'h1)
    else $error("self-test display ended early");
  a_warm_end: assert property (cnt_r == WARM + 12 |-> disp_msg != 3'h1)
    else $error("self-test display lasted too long");
  c_alarm: cover property ($rose(alarm_relay[0]));
  c_lamp: cover property (disp_msg == 3'h6);
  c_under: cover property (disp_msg == 3'h3);
endmodule
bind gas_supervisor gas_sup_sva #(.TICK_CYC(TICK_CYC), .WARMUP_T(WARMUP_T)) u_sva (
  .core_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .equip_fault, .alarm_relay, .alarm_led, .trouble_relay, .trouble_led,
  .seven_segment_display, .disp_msg, .disp_blank);

// ### dv/gas_field_model.sv
`timescale 1ns/100ps
module gas_field_model
(
  input logic core_clk,
  input logic [15:0] set_level,
  input logic [3:0] set_flags,
  output logic [15:0] sensor_level,
  output logic sensor_absent,
  output logic sensor_fault,
  output logic sensor_board_missing,
  output logic equip_fault
);
  // Front end converts once per clock, so the level lags the set point by one cycle
  initial
  begin
    sensor_level = 16'h0000;
    {equip_fault, sensor_board_missing, sensor_fault, sensor_absent} = 4'h0;
  end
  always @(posedge core_clk)
  begin
    sensor_level <= set_level;
    {equip_fault, sensor_board_missing, sensor_fault, sensor_absent} <= set_flags;
  end
endmodule

// ### dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic [3:0] s_axi_wstrb = 4'hF, flt = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ext_reset_short = 1'b0;
  logic [5:0] keys = 6'h00;
  logic [15:0] lvl = 16'h0000;
  logic [1:0] rr;
  logic on_seen, off_seen;
  int mismatches = 0, n_checks = 0;
  wire key_test = keys[0], function_key = keys[1], key_reset = keys[2];
  wire key_up = keys[3], key_down = keys[4], buzzer_silence_key = keys[5];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] sensor_level, seven_segment_display;
  wire sensor_absent, sensor_fault, sensor_board_missing, equip_fault;
  wire [2:0] alarm_relay, alarm_led, disp_msg;
  wire trouble_relay, trouble_led, warn_lamp, buzzer, disp_blank;
  logic [41:0] rows [11] = '{{8'h00, 32'h1, 2'h0}, {8'h04, 32'h14, 2'h0},
    {8'h08, 32'h28, 2'h0}, {8'h0C, 32'h32, 2'h0}, {8'h10, 32'h10101, 2'h0},
    {8'h14, 32'h64, 2'h0}, {8'h18, 32'h0, 2'h0}, {8'h1C, 32'h0, 2'h0},
    {8'h20, 32'h100, 2'h0}, {8'h24, 32'h0, 2'h0}, {8'h30, 32'h0, 2'h2}};
  always #12.5 core_clk = ~core_clk;
  gas_field_model u_field (.core_clk, .set_level(lvl), .set_flags(flt), .sensor_level,
    .sensor_absent, .sensor_fault, .sensor_board_missing, .equip_fault);
  gas_supervisor #(.TICK_CYC(4), .SEC_T(10), .WARMUP_T(50), .HOLD_T(5),
    .TEST_TO_T(100)) DUT (.core_clk, .reset, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sensor_level,
    .sensor_absent, .sensor_fault, .sensor_board_missing, .equip_fault, .key_test,
    .function_key, .key_reset, .key_up, .key_down, .buzzer_silence_key, .ext_reset_short,
    .alarm_relay, .trouble_relay, .alarm_led, .trouble_led, .warn_lamp, .buzzer,
    .seven_segment_display, .disp_msg, .disp_blank);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic hold(input int k, input int n);
    keys[k] <= 1'b1;
    cyc(n);
    keys[k] <= 1'b0;
    cyc(2);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic st(input logic [2:0] e);
    axr(8'h20);
    chk("state", e, rd[10:8]);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end
  initial
  begin
    cyc(4);
    reset <= 1'b0;
    chk("relay", 3'h0, alarm_relay);
    cyc(150);
    chk("msg", 3'h1, disp_msg);
    cyc(80);
    chk("msg", 3'h0, disp_msg);
    foreach (rows[i])
    begin
      axr(rows[i][41:34]);
      chk("rdata", rows[i][33:2], rd);
      chk("rresp", rows[i][1:0], rr);
    end
    axw(8'h30, 32'h0);
    chk("bresp", 2'h2, rr);
    s_axi_wstrb <= 4'h1;
    axw(8'h14, 32'hAB64);
    s_axi_wstrb <= 4'hF;
    axr(8'h14);
    chk("wstrb", 32'h64, rd);
    $display("registers done");
    repeat (4)
    begin
      lvl <= 16'h0020;
      cyc(35);
      lvl <= 16'h0000;
      cyc(4);
    end
    chk("relay", 3'h0, alarm_relay);
    lvl <= 16'h0020;
    cyc(36);
    chk("relay", 3'h0, alarm_relay);
    cyc(104);
    chk("relay", 3'h1, alarm_relay);
    lvl <= 16'h0025;
    cyc(5);
    lvl <= 16'h0000;
    cyc(5);
    chk("relay", 3'h1, alarm_relay);
    chk("peak", 16'h0025, seven_segment_display);
    ext_reset_short <= 1'b1;
    cyc(2);
    ext_reset_short <= 1'b0;
    cyc(2);
    chk("relay", 3'h0, alarm_relay);
    axw(8'h00, 32'h0);
    lvl <= 16'h0020;
    cyc(140);
    lvl <= 16'h0014;
    cyc(4);
    chk("relay", 3'h1, alarm_relay);
    lvl <= 16'h0013;
    cyc(4);
    chk("relay", 3'h0, alarm_relay);
    $display("alarm done");
    lvl <= 16'hFFF5;
    cyc(6);
    chk("msg", 3'h3, disp_msg);
    chk("trouble", 1'b1, trouble_relay);
    chk("buzzer", 1'b1, buzzer);
    hold(5, 2);
    chk("buzzer", 1'b0, buzzer);
    chk("warn", 1'b1, warn_lamp);
    lvl <= 16'hFFF6;
    cyc(6);
    chk("msg", 3'h0, disp_msg);
    lvl <= 16'h006F;
    cyc(6);
    chk("msg", 3'h4, disp_msg);
    chk("buzzer", 1'b1, buzzer);
    on_seen = 1'b0;
    off_seen = 1'b0;
    repeat (2010)
    begin
      @(posedge core_clk);
      on_seen |= (alarm_led === 3'h7);
      off_seen |= (alarm_led === 3'h0);
    end
    chk("flicker", 2'h3, {on_seen, off_seen});
    lvl <= 16'h006E;
    cyc(6);
    chk("msg", 3'h0, disp_msg);
    lvl <= 16'h0000;
    for (int k = 0; k < 3; k++)
    begin
      flt <= 4'h1 << k;
      cyc(30);
      chk("msg", 3'h2, disp_msg);
      chk("trouble", 1'b1, trouble_relay);
      flt <= 4'h0;
      cyc(6);
    end
    $display("range done");
    hold(0, 28);
    st(3'h2);
    axw(8'h18, 32'h30);
    cyc(140);
    chk("relay", 3'h3, alarm_relay);
    chk("value", 16'h0030, seven_segment_display);
    hold(5, 2);
    chk("buzzer", 1'b1, buzzer);
    hold(1, 28);
    st(3'h3);
    hold(2, 2);
    st(3'h1);
    hold(0, 28);
    cyc(340);
    st(3'h2);
    cyc(60);
    st(3'h1);
    $display("test mode done");
    hold(1, 28);
    st(3'h4);
    chk("unlock", 1'b1, rd[15]);
    hold(3, 2);
    axr(8'h20);
    chk("menu", 3'h1, rd[14:12]);
    hold(4, 2);
    hold(4, 2);
    axr(8'h20);
    chk("menu", 3'h6, rd[14:12]);
    cyc(100);
    st(3'h4);
    cyc(40000);
    st(3'h1);
    $display("setup done");
    flt <= 4'h8;
    reset <= 1'b1;
    cyc(4);
    reset <= 1'b0;
    cyc(230);
    st(3'h5);
    chk("trouble", 1'b1, trouble_relay);
    $display("equipment fault done");
    report_and_stop();
  end
endmodule
